// [tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clk_i = 1'b0, rst_i = 1'b1, srec = 1'b0, pdat = 1'b0;
  logic        cyc = 1'b0, we = 1'b0, edg = 1'b0, clr = 1'b0;
  logic [5:0]  adr = 6'h00;
  logic [3:0]  sl = 4'hF;
  logic        p6 = 1'b0;
  logic [31:0] dat = 32'h0, exp_q [$], msk_q [$];
  wire  [31:0] rdat;
  wire  [15:0] tgl;
  wire         ack, irq, pin5, pin6, nrun, dmd, nout;
  int          num_errors = 0, cmp_count = 0, tn = 0, cyc_n = 0, cnt [4];
  integer      seed = 32'h44e55042;
  wtc_counter16_control dut_u (.clk_i(clk_i), .rst_i(rst_i),
    .stop_recover_i(srec), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sl), .wb_dat_i(dat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .demod_in_i(dmd), .port_data_i(pdat),
    .narrow_out_i(nout), .port3_pin5_o(pin5), .port3_pin6_o(pin6),
    .narrow_run_o(nrun), .irq_o(irq));
  wtc_port3_model mdl_u (.clk_i(clk_i), .edge_i(edg), .clr_i(clr),
    .pin5_i(pin5), .demod_o(dmd), .narrow_o(nout), .toggles_o(tgl));
  always #4 clk_i = ~clk_i;
  // random port data keeps the pin mux busy
  always @(posedge clk_i)
    pdat <= 1'($random(seed));
  task chk(input logic ok);
    cmp_count++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("Error at %0t: value differs", $time);
    end
  endtask
  task bus(input logic [3:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_i);
    {cyc, we, adr, dat} <= {1'b1, w, a, 2'b00, d};
    do @(posedge clk_i); while (ack !== 1'b1);
    cyc <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    bus(a, 1'b0, 32'h0);
  endtask
  task pulse_edge;
    edg <= 1'b1;
    @(posedge clk_i);
    edg <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask
  task zap;
    repeat (3) @(posedge clk_i);
    clr <= 1'b1;
    @(posedge clk_i);
    clr <= 1'b0;
  endtask
  task done;
    $display("test %0d done", tn);
    tn++;
  endtask
  task tally_and_finish;
    $display("checks %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // read data is judged against the oldest note
  always @(posedge clk_i)
    if (ack === 1'b1 && !we && exp_q.size() > 0)
      chk((rdat & msk_q.pop_front()) === exp_q.pop_front());
  // hang guard, far above the little over a thousand cycles needed
  always @(posedge clk_i)
    if (++cyc_n == 20000) begin
      num_errors++;
      tally_and_finish();
    end
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(4'h2, 32'h0, 32'hFFFFFFFF);
    rd(4'h3, 32'h0, 32'hFFFFFFFF);
    rd(4'h6, 32'hFFFF, 32'hFFFFFFFF);
    // a write without byte lane 0 must be ignored
    sl <= 4'hE;
    bus(4'h6, 1'b1, 32'h1234);
    sl <= 4'hF;
    rd(4'h6, 32'hFFFF, 32'hFFFFFFFF);
    // pin 6 follows port data while the narrow route bit is clear
    for (int k = 0; k < 4; k++) begin
      @(posedge clk_i) p6 = pdat;
      @(negedge clk_i) chk(pin6 === p6);
    end
    bus(4'hF, 1'b1, 32'hFF);
    rd(4'hF, 32'h0, 32'hFFFFFFFF);
    bus(4'h6, 1'b1, 32'h100);
    bus(4'h2, 1'b1, 32'h80);
    rd(4'h2, 32'h80, 32'hFF);
    bus(4'h2, 1'b1, 32'h0);
    rd(4'h2, 32'h0, 32'h80);
    done();
    // each prescale step should halve the toggle rate
    bus(4'h6, 1'b1, 32'h3);
    for (int d = 0; d < 4; d++) begin
      bus(4'h2, 1'b1, 32'h83 | (d << 3));
      zap();
      repeat (200) @(posedge clk_i);
      cnt[d] = tgl;
    end
    chk(cnt[0] > 20);
    for (int d = 0; d < 3; d++)
      chk(cnt[d+1]*2 <= cnt[d]+2 && cnt[d+1]*2+2 >= cnt[d]);
    chk(irq === 1'b0);
    done();
    bus(4'h2, 1'b1, 32'h0);
    bus(4'h8, 1'b1, 32'h3);
    bus(4'h9, 1'b1, 32'h1);
    bus(4'h6, 1'b1, 32'h4);
    bus(4'h2, 1'b1, 32'hC3);
    zap();
    repeat (100) @(posedge clk_i);
    chk(tgl === 16'h1);
    chk(irq === 1'b1);
    rd(4'h8, 32'h1, 32'h1);
    bus(4'h2, 1'b1, 32'h3);
    rd(4'h2, 32'h20, 32'h20);
    bus(4'h2, 1'b1, 32'h20);
    rd(4'h2, 32'h0, 32'h20);
    bus(4'h8, 1'b1, 32'h1);
    @(posedge clk_i);
    chk(irq === 1'b0);
    done();
    // each of the falling, rising and both edge codes raises a capture interrupt
    bus(4'h2, 1'b1, 32'h84);
    bus(4'h9, 1'b1, 32'h2);
    for (int e = 0; e < 3; e++) begin
      bus(4'h4, 1'b1, 32'h40 | e);
      bus(4'h8, 1'b1, 32'h3);
      pulse_edge();
      pulse_edge();
      chk(irq === 1'b1);
      rd(4'h8, 32'h2, 32'h2);
    end
    // a captured value stays below eight, with the reload value at four
    rd(4'h7, 32'h0, 32'hFFF8);
    bus(4'h2, 1'b1, 32'h80);
    bus(4'h8, 1'b1, 32'h3);
    pulse_edge();
    rd(4'h8, 32'h0, 32'h2);
    bus(4'h2, 1'b1, 32'h0);
    bus(4'h2, 1'b1, 32'hC4);
    pulse_edge();
    bus(4'h8, 1'b1, 32'h3);
    pulse_edge();
    rd(4'h8, 32'h0, 32'h2);
    done();
    bus(4'h2, 1'b1, 32'h9C);
    srec <= 1'b1;
    @(posedge clk_i);
    srec <= 1'b0;
    rd(4'h2, 32'h1C, 32'hFF);
    bus(4'h3, 1'b1, 32'hC0);
    rd(4'h3, 32'hC0, 32'hFF);
    chk(nrun === 1'b1);
    done();
    tally_and_finish();
  end
endmodule // tb_top
`default_nettype wire

// [wtc_consts.vh]
`ifndef WTC_CONSTS_VH
`define WTC_CONSTS_VH
// register word offsets (byte address = 4 * index)
`define WTC_IDX_CTL      4'h2
`define WTC_IDX_SYNC     4'h3
`define WTC_IDX_SHARED   4'h4
`define WTC_IDX_NARROW   4'h5
`define WTC_IDX_RELOAD   4'h6
`define WTC_IDX_CAPTURE  4'h7
`define WTC_IDX_IRQ_STAT 4'h8
`define WTC_IDX_IRQ_MASK 4'h9
// wide_timer_ctl fields
`define WTC_B_RUN        7
`define WTC_B_SINGLE     6
`define WTC_B_TIMEOUT    5
`define WTC_B_CLK_HI     4
`define WTC_B_CLK_LO     3
`define WTC_B_CAP_IE     2
`define WTC_B_TO_IE      1
`define WTC_B_ROUTE      0
// timer_sync_ctl fields
`define WTC_B_SYNC_WIDE  7
`define WTC_B_SYNC_NARR  6
`define WTC_B_SYNC_EN    5
// shared_timer_ctl fields
`define WTC_B_DEMOD      6
`define WTC_B_EDGE_HI    1
`define WTC_B_EDGE_LO    0
// edge select codes
`define WTC_EDGE_FALL    2'h0
`define WTC_EDGE_RISE    2'h1
`define WTC_EDGE_BOTH    2'h2
// irq status bits
`define WTC_IRQ_TO       0
`define WTC_IRQ_CAP      1
// reset values and other constants
`define WTC_CTL_RST      8'h00
`define WTC_SYNC_RST     8'h00
`define WTC_RELOAD_RST   16'hFFFF
`define WTC_ZERO16       16'h0000
`define WTC_ONE16        16'h0001
`define WTC_ZERO3        3'h0
`define WTC_ONE3         3'h1
`define WTC_MASK_CTL     8'hDF
`define WTC_ZERO2        2'h0
// narrow_timer_ctl bit that hands pin 6 to the timer logic
`define WTC_B_NARROW_ROUTE 0
`endif

// [wtc_counter16_control.v]
// The implementer's own choice: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "wtc_consts.vh"

// Contract
// - bit 7 of wide_timer_ctl reads the run state and a write starts or stops it.
// - transmit mode with bit 6 clear reloads at terminal count and keeps running.
// - transmit mode with bit 6 set halts at terminal count.
// - demodulation with bit 6 clear captures and reloads on every detected edge.
// - demodulation with bit 6 set captures on the first edge and ignores later ones.
// - bit 5 is set at terminal count and cleared by writing one to it.
// - bits 4:3 pick the count clock as system clock divided by 1, 2, 4 or 8.
// - bit 2 enables the interrupt on each capture.
// - bit 1 enables the interrupt on timeout.
// - bit 0 routes port3_pin5 between port data and the counter output.
// - power-on reset clears all fields; clock select and capture enable survive stop recovery.
// - port 3 output routing uses wide bit 0 for pin 5 and narrow bit 0 for pin 6; shared bits 5:4 take no part.
// - in demodulation a shared two-bit field picks falling, rising or both edges.
module wtc_counter16_control (
  // clock and resets
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        stop_recover_i,
  // wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [5:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output wire [31:0] wb_dat_o,
  output wire        wb_ack_o,
  // port 3 and demodulator input
  input  wire        demod_in_i,
  input  wire        port_data_i,
  input  wire        narrow_out_i,
  output reg         port3_pin5_o,
  output reg         port3_pin6_o,
  output reg         narrow_run_o,
  // interrupt
  output wire        irq_o
);

  // registers
  reg        run;
  reg        single;
  reg        timeout;
  reg  [1:0] clk_sel;
  reg        cap_ie;
  reg        to_ie;
  reg        route;
  reg        narrow_run;
  reg        sync_en;
  reg  [7:0] shared_ctl;
  reg  [7:0] narrow_ctl;
  reg [15:0] reload;
  reg [15:0] count;
  reg [15:0] capture;
  reg  [1:0] irq_stat;
  reg  [1:0] irq_mask;
  reg        wide_out;
  reg        demod_q;
  reg        edge_seen;
  reg        ack;
  reg  [2:0] presc;
  reg [31:0] rdata;

  wire       wr     = wb_cyc_i & wb_stb_i & wb_we_i & ~ack & wb_sel_i[0];
  wire [3:0] idx    = wb_adr_i[5:2];
  wire [7:0] wdat   = wb_dat_i[7:0];
  wire       demod  = shared_ctl[`WTC_B_DEMOD];
  wire [1:0] edge_s = shared_ctl[`WTC_B_EDGE_HI:`WTC_B_EDGE_LO];

  // address match for one register index
  function wtc_sel;
    input [3:0] a;
    input [3:0] b;
    begin
      wtc_sel = (a == b);
    end
  endfunction

  // per-register write strobes, decoded once so every writer agrees
  wire wr_ctl    = wr & wtc_sel(idx, `WTC_IDX_CTL);
  wire wr_sync   = wr & wtc_sel(idx, `WTC_IDX_SYNC);
  wire wr_shared = wr & wtc_sel(idx, `WTC_IDX_SHARED);
  wire wr_narrow = wr & wtc_sel(idx, `WTC_IDX_NARROW);
  wire wr_reload = wr & wtc_sel(idx, `WTC_IDX_RELOAD);
  wire wr_stat   = wr & wtc_sel(idx, `WTC_IDX_IRQ_STAT);
  wire wr_mask   = wr & wtc_sel(idx, `WTC_IDX_IRQ_MASK);

  // prescaler terminal value for a clock select code
  function [2:0] wtc_div_last;
    input [1:0] sel;
    begin
      wtc_div_last = (3'h1 << sel) - 3'h1;
    end
  endfunction

  // one-cycle tick per prescaled period; hold while stopped so the
  // first tick after start is a full period
  wire tick = run & (presc == wtc_div_last(clk_sel));

  always @(posedge clk_i) begin
    if (rst_i | ~run) begin
      presc <= `WTC_ZERO3;
    end else if (tick) begin
      presc <= `WTC_ZERO3;
    end else begin
      presc <= presc + `WTC_ONE3;
    end
  end

  // edge detection on the demodulator input; demod_q resets low to
  // match the idle level of the line, so reset gives no false edge
  wire rise = demod_in_i & ~demod_q;
  wire fall = ~demod_in_i & demod_q;
  wire edge_hit = (edge_s == `WTC_EDGE_FALL) ? fall :
                  (edge_s == `WTC_EDGE_RISE) ? rise :
                  (edge_s == `WTC_EDGE_BOTH) ? (rise | fall) :
                  1'b0;
  wire cap_ev = run & demod & edge_hit & ~(single & edge_seen);
  wire tc     = tick & (count == `WTC_ZERO16);
  wire to_ev  = tc;

  // register writes and hardware updates
  always @(posedge clk_i) begin
    if (rst_i) begin
      run        <= 1'b0;
      single     <= 1'b0;
      timeout    <= 1'b0;
      clk_sel    <= `WTC_ZERO2;
      cap_ie     <= 1'b0;
      to_ie      <= 1'b0;
      route      <= 1'b0;
      narrow_run <= 1'b0;
      sync_en    <= 1'b0;
      shared_ctl <= `WTC_CTL_RST;
      narrow_ctl <= `WTC_CTL_RST;
      reload     <= `WTC_RELOAD_RST;
      irq_mask   <= `WTC_ZERO2;
    end else if (stop_recover_i) begin
      // clock select and capture enable survive recovery
      // recovery may land mid count: the run bit drops and the
      // counter freezes where it stood until software restarts it
      run        <= 1'b0;
      single     <= 1'b0;
      timeout    <= 1'b0;
      to_ie      <= 1'b0;
      route      <= 1'b0;
      narrow_run <= 1'b0;
      sync_en    <= 1'b0;
    end else begin
      if (wr_ctl) begin
        run     <= wdat[`WTC_B_RUN];
        single  <= wdat[`WTC_B_SINGLE];
        clk_sel <= wdat[`WTC_B_CLK_HI:`WTC_B_CLK_LO];
        cap_ie  <= wdat[`WTC_B_CAP_IE];
        to_ie   <= wdat[`WTC_B_TO_IE];
        route   <= wdat[`WTC_B_ROUTE];
      end else if (wr_sync) begin
        // sync mode sets both run bits in the same cycle; narrow_run_o follows a cycle later
        run        <= wdat[`WTC_B_SYNC_WIDE];
        narrow_run <= wdat[`WTC_B_SYNC_NARR];
        sync_en    <= wdat[`WTC_B_SYNC_EN];
      end else if (tc & ~demod & single) begin
        run <= 1'b0;
      end
      // set wins over a same-cycle write-one clear
      if (to_ev) begin
        timeout <= 1'b1;
      end else if (wr_ctl && wdat[`WTC_B_TIMEOUT]) begin
        timeout <= 1'b0;
      end
      // shared and narrow controls only steer pin 6, the edge choice and the demodulation mode here
      if (wr_shared) begin
        shared_ctl <= wdat;
      end
      if (wr_narrow) begin
        narrow_ctl <= wdat;
      end
      // reload takes the whole low half-word in one write
      if (wr_reload) begin
        reload <= wb_dat_i[15:0];
      end
      if (wr_mask) begin
        irq_mask <= wdat[1:0];
      end
    end
  end

  // counter core: counts down from the reload value
  // limitation: a start through the sync register does not reload;
  // software uses the control register to begin from the initial value
  // a start write outranks a same-cycle capture so a run begins clean
  always @(posedge clk_i) begin
    if (rst_i) begin
      count     <= `WTC_RELOAD_RST;
      capture   <= `WTC_ZERO16;
      wide_out  <= 1'b0;
      demod_q   <= 1'b0;
      edge_seen <= 1'b0;
    end else begin
      demod_q <= demod_in_i;
      if (wr_ctl && wdat[`WTC_B_RUN] && !run) begin
        count     <= reload; // fresh start loads the initial value
        edge_seen <= 1'b0;
      end else if (cap_ev) begin
        capture   <= count;
        count     <= reload;
        edge_seen <= 1'b1;
      end else if (tc) begin
        wide_out <= ~wide_out;
        if (!single || demod) begin
          count <= reload;
        end
      end else if (tick) begin
        count <= count - `WTC_ONE16;
      end
    end
  end

  // interrupt status: sticky, write one to clear, set wins
  wire [1:0] irq_set = {cap_ev & cap_ie, to_ev & to_ie};
  wire [1:0] irq_clr = wr_stat ? wdat[1:0] : `WTC_ZERO2;

  always @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat <= 2'h0;
    end else begin
      irq_stat <= irq_set | (irq_stat & ~irq_clr);
    end
  end

  // combinational on purpose: the line drops in the cycle in which
  // the clearing write lands, not one cycle later
  assign irq_o = |(irq_stat & irq_mask);

  // port 3 routing; pin 6 is the shared output when enabled
  // registered so the pins never glitch while a route bit changes
  always @(posedge clk_i) begin
    if (rst_i) begin
      port3_pin5_o <= 1'b0;
      port3_pin6_o <= 1'b0;
      narrow_run_o <= 1'b0;
    end else begin
      port3_pin5_o <= route ? wide_out : port_data_i;
      port3_pin6_o <= narrow_ctl[`WTC_B_NARROW_ROUTE] ? (wide_out ^ narrow_out_i)
                                    : port_data_i;
      narrow_run_o <= narrow_run;
    end
  end

  // read mux; unused bits read zero so software can mask freely
  always @* begin
    rdata = 32'h0000_0000;
    case (idx)
      `WTC_IDX_CTL:      rdata[7:0] = {run, single, timeout, clk_sel,
                                       cap_ie, to_ie, route};
      `WTC_IDX_SYNC:     rdata[7:0] = {run, narrow_run, sync_en, 5'h00};
      `WTC_IDX_SHARED:   rdata[7:0] = shared_ctl;
      `WTC_IDX_NARROW:   rdata[7:0] = narrow_ctl;
      `WTC_IDX_RELOAD:   rdata[15:0] = reload;
      `WTC_IDX_CAPTURE:  rdata[15:0] = capture;
      `WTC_IDX_IRQ_STAT: rdata[1:0] = irq_stat;
      `WTC_IDX_IRQ_MASK: rdata[1:0] = irq_mask;
      default:           rdata = 32'h0000_0000;
    endcase
  end

  // bus timing: a request is taken at the edge that sees cyc and stb
  // with ack low, writes land there, and ack plus the registered read
  // data stand for exactly the next cycle; the ~ack term keeps a held
  // request from being taken twice
  reg [31:0] dat_q;
  // ack one cycle after request, dropped the following cycle
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack   <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack   <= wb_cyc_i & wb_stb_i & ~ack;
      dat_q <= rdata;
    end
  end

  assign wb_ack_o = ack;
  assign wb_dat_o = dat_q;

endmodule // wtc_counter16_control
`default_nettype wire

// [wtc_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
`include "wtc_consts.vh"
module wtc_monitor (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // wishbone side
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [5:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // pins and interrupt
  input wire logic        port_data_i,
  input wire logic        port3_pin5_o,
  input wire logic        narrow_run_o,
  input wire logic        irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire       take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire       wr0  = take & wb_we_i & wb_sel_i[0];
  wire [3:0] idx  = wb_adr_i[5:2];
  logic       route;
  logic [1:0] mask;
  // shadows taken at the request edge, the same edge at which the DUT registers load
  always @(posedge clk_i)
    if (rst_i)
      {route, mask} <= 3'h0;
    else if (wr0 && idx == `WTC_IDX_CTL)
      route <= wb_dat_i[0];
    else if (wr0 && idx == `WTC_IDX_IRQ_MASK)
      mask <= wb_dat_i[1:0];
  sequence s_rd(i);
    take && !wb_we_i && idx == i ##1 wb_ack_o;
  endsequence
  AST_ACK_NEXT: assert property (take |=> wb_ack_o)
    else $error("ack missing");
  AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  AST_UNMAPPED: assert property (s_rd(4'hF) |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  AST_CTL_HIGH: assert property (s_rd(`WTC_IDX_CTL) |-> !wb_dat_o[31:8])
    else $error("control upper bits set");
  AST_RST_OUT: assert property ($fell(rst_i) |-> !irq_o && !narrow_run_o)
    else $error("outputs not cleared");
  AST_PIN5: assert property (!$past(rst_i) && !$past(route)
    && !$past(route, 2) |-> port3_pin5_o == $past(port_data_i))
    else $error("pin5 not port data");
  AST_IRQ_MASK: assert property (!mask && !$past(mask) |-> !irq_o)
    else $error("irq while masked");
  AST_SYNC_RUN: assert property (wr0 && idx == `WTC_IDX_SYNC
    && wb_dat_i[`WTC_B_SYNC_NARR] |-> ##[1:3] narrow_run_o)
    else $error("narrow run not set");
endmodule // wtc_monitor
bind wtc_counter16_control wtc_monitor mon_u (.*);
`default_nettype wire

// [wtc_port3_model.sv]
`timescale 1ns/1ps
`default_nettype none
module wtc_port3_model (
  // bench control
  input  wire logic        clk_i,
  input  wire logic        edge_i,
  input  wire logic        clr_i,
  // port 3 pins
  input  wire logic        pin5_i,
  output var  logic        demod_o,
  output var  logic        narrow_o,
  output var  logic [15:0] toggles_o
);
  logic last = 1'b0;
  initial {demod_o, narrow_o, toggles_o} = 18'h0;
  // demod flips on request; narrow output never idles
  always @(posedge clk_i) begin
    demod_o <= demod_o ^ edge_i;
    narrow_o <= ~narrow_o;
    last <= pin5_i;
    toggles_o <= clr_i ? 16'h0 : toggles_o + {15'h0, pin5_i != last};
  end
endmodule // wtc_port3_model
`default_nettype wire
